// File: rtl/adc_instr_map.svh
// Constants for the serial instruction decoder: status bit positions,
// mode nibble codes, acquisition choices and power-on defaults.
// Assumes inclusion by the shifter and decoder top modules; the package does not include it.
`ifndef ADC_INSTR_MAP_SVH
`define ADC_INSTR_MAP_SVH

`define INSTR_BITS        8
`define STATUS_BITS       9
`define ST_PU             0
`define ST_PD             1
`define ST_CAL            2
`define ST_LEN8           3
`define ST_LEN12          4
`define ST_LEN16          5
`define ST_SIGN           6
`define ST_MSB            7
`define ST_TEST           8

`define MODE_CONV12       4'h0
`define MODE_CONV16       4'h1
`define MODE_CONV8        4'h2
`define MODE_FULLSCALE    4'h3
`define MODE_CONV12_LSB   4'h4
`define MODE_CONV16_LSB   4'h5
`define MODE_CONV8_LSB    4'h6
`define MODE_OFFSET       4'h7
`define MODE_AUTOCAL      4'h8
`define MODE_AUTOZERO     4'h9
`define MODE_PWRUP        4'ha
`define MODE_PWRDN        4'hb
`define MODE_STATUS       4'hc
`define MODE_SIGN         4'hd
`define MODE_ACQ          4'he
`define MODE_USER         4'hf

`define ACQ_6             6'h06
`define ACQ_10            6'h0a
`define ACQ_18            6'h12
`define ACQ_34            6'h22
`define RESET_LEN         5'h0d
`define CAL_CYCLES        8'h40
`define PWR_CYCLES        8'h10

`endif

// File: rtl/adc_instr_pkg.sv
// Types shared by the instruction decoder modules.
// Assumes adc_instr_map.svh is on the include path.
`default_nettype none
package adc_instr_pkg;
   typedef enum logic [1:0] {WIDTH_8, WIDTH_12, WIDTH_16} out_width_t;
   typedef enum logic [2:0] {SER_IDLE, SER_SHIFT, SER_CONV, SER_CAL, SER_PWR} seq_state_t;
   typedef struct packed {
      out_width_t width;
      logic       sign_on;
      logic       msb_first;
   } out_fmt_t;
endpackage
`default_nettype wire

// File: rtl/adc_instr_if.sv
// Interface carrying decoded instruction fields between decoder parts.
// Assumes both ends run on the same clock.
`default_nettype none
interface adc_instr_if;
   logic       word_valid;
   logic [7:0] word;
   logic [4:0] frame_len;
   logic       frame_done;
   modport shifter (output word_valid, output word, input frame_len, output frame_done);
   modport decoder (input word_valid, input word, output frame_len, input frame_done);
endinterface
`default_nettype wire

// File: rtl/serial_shifter.sv
// Serial shifter: samples instruction bits and drives result bits on the
// serial clock edges found by the system clock. Inputs already synchronised.
`default_nettype none
`include "adc_instr_map.svh"
module serial_shifter #(
   parameter int OUT_W = 17
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             cs_n,
   input  wire logic             sclk_rise,
   input  wire logic             sclk_fall,
   input  wire logic             din,
   input  wire logic             load,
   input  wire logic [OUT_W-1:0] load_word,
   output logic                  dout,
   adc_instr_if.shifter          bus
);
   logic [7:0]       in_r,    in_nxt;
   logic [4:0]       cnt_r,   cnt_nxt;
   logic [OUT_W-1:0] out_r,   out_nxt;
   logic             done_r,  done_nxt;
   logic             wv_r,    wv_nxt;

   initial begin
      if (OUT_W != 17) $error("serial_shifter needs OUT_W of 17");
   end

   always_comb begin
      in_nxt   = in_r;
      cnt_nxt  = cnt_r;
      out_nxt  = out_r;
      done_nxt = 1'b0;
      wv_nxt   = 1'b0;
      if (load) begin
         out_nxt = load_word;
         cnt_nxt = 5'h00;
      end else if (cs_n) begin
         cnt_nxt = 5'h00;
      end else if (sclk_rise) begin
         // First eight bits form the instruction, rest are ignored
         if (cnt_r < 5'd8) in_nxt = {in_r[6:0], din};
         if (cnt_r == 5'd7) wv_nxt = 1'b1;
         if (cnt_r + 5'd1 == bus.frame_len) begin
            done_nxt = 1'b1;
            cnt_nxt  = 5'h00;
         end else begin
            cnt_nxt = cnt_r + 5'd1;
         end
      end else if (sclk_fall && cnt_r != 5'h00) begin
         // No shift after the last bit, so a word loaded at frame end stays intact
         out_nxt = {out_r[OUT_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_r   <= 8'h00;
         cnt_r  <= 5'h00;
         out_r  <= '0;
         done_r <= 1'b0;
         wv_r   <= 1'b0;
      end else begin
         in_r   <= in_nxt;
         cnt_r  <= cnt_nxt;
         out_r  <= out_nxt;
         done_r <= done_nxt;
         wv_r   <= wv_nxt;
      end
   end

   assign dout           = out_r[OUT_W-1];
   assign bus.word       = in_r;
   assign bus.word_valid = wv_r;
   assign bus.frame_done = done_r;
endmodule
`default_nettype wire

// File: rtl/adc_serial_instruction_decoder.sv
// Top of the serial instruction decoder: pin synchronisers, mode decode,
// configuration, sequencing of conversion, calibration and power steps.
// Assumes the serial clock is far slower than clk; the analog engine is outside.
`default_nettype none
`include "adc_instr_map.svh"
module adc_serial_instruction_decoder
#(
   parameter int ADDR_W = 4
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        chip_select_n,
   input  wire logic        serial_clock,
   input  wire logic        serial_instruction_in,
   input  wire logic        conv_inhibit,
   input  wire logic        power_down_pin,
   input  wire logic        conversion_clock,
   input  wire logic        conv_done,
   input  wire logic [12:0] conv_result,
   output logic             serial_data_out,
   output logic             conv_start,
   output logic             conv_abort,
   output logic [1:0]       conv_kind,
   output logic             conv_8bit,
   output logic             single_ended,
   output logic             swap_polarity,
   output logic [2:0]       channel_sel,
   output logic [5:0]       acq_cycles,
   output logic             converter_powered,
   output logic             test_drive,
   output logic [8:0]       device_status_word
);
   import adc_instr_pkg::*;

   initial begin
      if (ADDR_W < 2 || ADDR_W > 4) $error("ADDR_W must be 2, 3 or 4");
   end

   // Two-stage synchronisers for the six serial and control pins (not conv_done or conv_result); reset to idle levels, so no false edge
   logic [5:0] s1_r, s2_r, s3_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= 6'h10;
         s2_r <= 6'h10;
         s3_r <= 6'h10;
      end else begin
         s1_r <= {conversion_clock, chip_select_n, serial_clock, serial_instruction_in,
                  conv_inhibit, power_down_pin};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic cs_s, sck_s, din_s, inh_s, pd_s, sck_d;
   assign cs_s  = s2_r[4];
   assign sck_s = s2_r[3];
   assign din_s = s2_r[2];
   assign inh_s = s2_r[1];
   assign pd_s  = s2_r[0];
   assign sck_d = s3_r[3];

   logic conversion_clock_tick;
   assign conversion_clock_tick = s2_r[5] & ~s3_r[5];

   adc_instr_if ibus ();
   logic        load;
   logic [16:0] load_word;
   logic        dout_w;

   serial_shifter #(.OUT_W(17)) u_shift (
      .clk       (clk),
      .rst_n     (rst_n),
      .cs_n      (cs_s),
      .sclk_rise (sck_s & ~sck_d),
      .sclk_fall (~sck_s & sck_d),
      .din       (din_s),
      .load      (load),
      .load_word (load_word),
      .dout      (dout_w),
      .bus       (ibus.shifter)
   );

   // Configuration and sequencing state
   out_fmt_t    fmt_r,   fmt_nxt;
   logic [5:0]  acq_r,   acq_nxt;
   logic        pwr_r,   pwr_nxt;
   logic        test_r,  test_nxt;
   logic        stsel_r, stsel_nxt;
   logic        pend_r,  pend_nxt;
   logic        cal_r,   cal_nxt;
   logic        pu_r,    pu_nxt;
   logic        pdp_r,   pdp_nxt;
   logic [7:0]  tmr_r,   tmr_nxt;
   seq_state_t  st_r,    st_nxt;
   logic [12:0] res_r,   res_nxt;
   logic [1:0]  kind_r,  kind_nxt;
   logic        c8_r,    c8_nxt;
   logic        se_r,    se_nxt;
   logic        sw_r,    sw_nxt;
   logic [2:0]  ch_r,    ch_nxt;
   logic        start_r, start_nxt;
   logic        abort_r, abort_nxt;
   logic [4:0]  len_r,   len_nxt;
   logic        cs_prev_r;
   logic [8:0]  status_w;

   logic [7:0] w;
   logic [3:0] addr, mode;
   logic       addr_zero;
   always_comb begin
      w    = ibus.word;
      // Address occupies the leading ADDR_W bits, mode follows
      addr = 4'h0;
      mode = 4'h0;
      case (ADDR_W)
         2:       begin addr = {w[7:6], 2'b00}; mode = w[5:2]; end
         3:       begin addr = {w[7:5], 1'b0};  mode = w[4:1]; end
         default: begin addr = w[7:4];          mode = w[3:0]; end
      endcase
      addr_zero = (addr == 4'h0);
   end

   function automatic logic [4:0] frame_length(input out_fmt_t f);
      logic [4:0] b;
      case (f.width)
         WIDTH_8:  b = 5'd8;
         WIDTH_16: b = 5'd16;
         default:  b = 5'd12;
      endcase
      return b + {4'h0, f.sign_on};
   endfunction

   // Result formatted for the current output word, left aligned on 17 bits
   function automatic logic [16:0] format_word(input out_fmt_t f, input logic [12:0] r);
      logic [16:0] v;
      logic [12:0] rr;
      logic [12:0] q;
      int          i;
      q = (f.width == WIDTH_8) ? {{4{r[12]}}, r[12], r[11:4]} : r;
      v = 17'h0_0000;
      rr = 13'h0000;
      for (i = 0; i < 13; i++) rr[i] = q[12-i];
      if (f.msb_first) begin
         case (f.width)
            WIDTH_8:  v = f.sign_on ? {q[8:0], 8'h00} : {q[7:0], 9'h000};
            WIDTH_16: v = f.sign_on ? {4'h0, q} : {4'h0, q[11:0], 1'b0};
            default:  v = f.sign_on ? {q, 4'h0} : {q[11:0], 5'h00};
         endcase
      end else begin
         case (f.width)
            WIDTH_8:  v = {rr[12:4], 8'h00} & (f.sign_on ? 17'h1_ff00 : 17'h1_fe00);
            default:  v = {rr, 4'h0} & (f.sign_on ? 17'h1_fff0 : 17'h1_ffe0);
         endcase
      end
      return v;
   endfunction

   always_comb begin
      status_w = 9'h000;
      status_w[`ST_PU]    = pu_r;
      status_w[`ST_PD]    = pdp_r;
      status_w[`ST_CAL]   = cal_r;
      status_w[`ST_LEN8]  = (fmt_r.width == WIDTH_8);
      status_w[`ST_LEN12] = (fmt_r.width == WIDTH_12);
      status_w[`ST_LEN16] = (fmt_r.width == WIDTH_16);
      status_w[`ST_SIGN]  = fmt_r.sign_on;
      status_w[`ST_MSB]   = fmt_r.msb_first;
      status_w[`ST_TEST]  = test_r;
   end

   always_comb begin
      fmt_nxt = fmt_r; acq_nxt = acq_r; pwr_nxt = pwr_r; test_nxt = test_r;
      stsel_nxt = stsel_r; pend_nxt = pend_r; cal_nxt = cal_r; pu_nxt = pu_r;
      pdp_nxt = pdp_r; tmr_nxt = tmr_r; st_nxt = st_r; res_nxt = res_r;
      kind_nxt = kind_r; c8_nxt = c8_r; se_nxt = se_r; sw_nxt = sw_r; ch_nxt = ch_r;
      start_nxt = 1'b0; abort_nxt = 1'b0;
      len_nxt = len_r;
      load = 1'b0; load_word = 17'h0_0000;

      // Next exchange presents status or last result
      if (cs_s && !cs_prev_r || ibus.frame_done) begin
         load      = 1'b1;
         load_word = stsel_r ? {status_w, 8'h00} : format_word(fmt_r, res_r);
      end

      if (st_r == SER_CONV) begin
         if (!cs_s && cs_prev_r) begin
            abort_nxt = 1'b1;
            st_nxt    = SER_IDLE;
         end else if (conv_done) begin
            res_nxt = conv_result;
            // Fresh result must wait in the shifter for the next exchange
            load      = 1'b1;
            load_word = format_word(fmt_r, conv_result);
            st_nxt  = SER_IDLE;
         end
      end else if (st_r == SER_CAL || st_r == SER_PWR) begin
         if (conversion_clock_tick) tmr_nxt = tmr_r - 8'd1;
         if (tmr_r == 8'd0) begin
            cal_nxt = 1'b0;
            pu_nxt  = 1'b0;
            pdp_nxt = 1'b0;
            st_nxt  = SER_IDLE;
         end
      end

      if (ibus.word_valid && !cs_s && !pd_s && !inh_s) begin
         stsel_nxt = 1'b0;
         pend_nxt  = 1'b0;
         case (mode)
            `MODE_CONV12, `MODE_CONV16, `MODE_CONV8,
            `MODE_CONV12_LSB, `MODE_CONV16_LSB, `MODE_CONV8_LSB: begin
               fmt_nxt.msb_first = ~mode[2];
               fmt_nxt.width = (mode[1:0] == 2'b01) ? WIDTH_16 :
                               (mode[1:0] == 2'b10) ? WIDTH_8 : WIDTH_12;
               c8_nxt   = (mode[1:0] == 2'b10);
               kind_nxt = 2'd0;
               se_nxt   = addr[3];
               sw_nxt   = addr[2];
               ch_nxt   = (ADDR_W == 2) ? {2'b00, addr[2] & addr[3]} :
                          (ADDR_W == 3) ? {1'b0, addr[1], addr[2] & addr[3]} :
                                          {addr[1:0], addr[2] & addr[3]};
               pend_nxt = 1'b1;
            end
            `MODE_FULLSCALE, `MODE_OFFSET: begin
               if (addr_zero) begin
                  fmt_nxt.width     = WIDTH_12;
                  fmt_nxt.msb_first = ~mode[2];
                  kind_nxt = mode[2] ? 2'd2 : 2'd1;
                  c8_nxt   = 1'b0;
                  pend_nxt = 1'b1;
               end
            end
            `MODE_AUTOCAL, `MODE_AUTOZERO: begin
               if (addr_zero) begin
                  cal_nxt = 1'b1;
                  tmr_nxt = mode[0] ? `PWR_CYCLES : `CAL_CYCLES;
                  st_nxt  = SER_CAL;
               end
            end
            `MODE_PWRUP, `MODE_PWRDN: begin
               if (addr_zero) begin
                  pwr_nxt = ~mode[0];
                  pu_nxt  = ~mode[0];
                  pdp_nxt = mode[0];
                  tmr_nxt = `PWR_CYCLES;
                  st_nxt  = SER_PWR;
               end
            end
            `MODE_STATUS:  if (addr_zero) stsel_nxt = 1'b1;
            `MODE_SIGN: begin
               if (addr[2:0] == 3'b000) fmt_nxt.sign_on = addr[3];
            end
            `MODE_ACQ: begin
               if (addr[1:0] == 2'b00) begin
                  case (addr[3:2])
                     2'b00:   acq_nxt = `ACQ_6;
                     2'b01:   acq_nxt = `ACQ_10;
                     2'b10:   acq_nxt = `ACQ_18;
                     default: acq_nxt = `ACQ_34;
                  endcase
               end
            end
            `MODE_USER: begin
               if (addr[3])        test_nxt = 1'b1;
               else if (addr_zero) test_nxt = 1'b0;
            end
            default: ;
         endcase
      end

      // Conversion starts when the instruction exchange ends
      // Includes this cycle's decode: in 8-bit frames word and frame end coincide
      if (pend_nxt && ibus.frame_done && st_r == SER_IDLE) begin
         pend_nxt  = 1'b0;
         start_nxt = 1'b1;
         st_nxt    = SER_CONV;
      end
      if (pd_s) pwr_nxt = 1'b0;
      // Length latched between frames, so a format change waits for the next one
      if (cs_s || ibus.frame_done) len_nxt = frame_length(fmt_nxt);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fmt_r   <= '{width: WIDTH_12, sign_on: 1'b1, msb_first: 1'b1};
         acq_r   <= `ACQ_10;
         pwr_r   <= 1'b1;
         test_r  <= 1'b0;
         stsel_r <= 1'b0;
         pend_r  <= 1'b0;
         cal_r   <= 1'b0;
         pu_r    <= 1'b0;
         pdp_r   <= 1'b0;
         tmr_r   <= 8'h00;
         st_r    <= SER_IDLE;
         res_r   <= 13'h0000;
         kind_r  <= 2'd0;
         c8_r    <= 1'b0;
         se_r    <= 1'b0;
         sw_r    <= 1'b0;
         ch_r    <= 3'h0;
         start_r <= 1'b0;
         abort_r <= 1'b0;
         len_r   <= `RESET_LEN;
         cs_prev_r <= 1'b1;
         serial_data_out    <= 1'b0;
         device_status_word <= 9'h000;
      end else begin
         fmt_r   <= fmt_nxt;
         acq_r   <= acq_nxt;
         pwr_r   <= pwr_nxt;
         test_r  <= test_nxt;
         stsel_r <= stsel_nxt;
         pend_r  <= pend_nxt;
         cal_r   <= cal_nxt;
         pu_r    <= pu_nxt;
         pdp_r   <= pdp_nxt;
         tmr_r   <= tmr_nxt;
         st_r    <= st_nxt;
         res_r   <= res_nxt;
         kind_r  <= kind_nxt;
         c8_r    <= c8_nxt;
         se_r    <= se_nxt;
         sw_r    <= sw_nxt;
         ch_r    <= ch_nxt;
         start_r <= start_nxt;
         abort_r <= abort_nxt;
         len_r   <= len_nxt;
         cs_prev_r <= cs_s;
         serial_data_out    <= dout_w;
         device_status_word <= status_w;
      end
   end

   assign ibus.frame_len    = len_r;
   assign conv_start        = start_r;
   assign conv_abort        = abort_r;
   assign conv_kind         = kind_r;
   assign conv_8bit         = c8_r;
   assign single_ended      = se_r;
   assign swap_polarity     = sw_r;
   assign channel_sel       = ch_r;
   assign acq_cycles        = acq_r;
   assign converter_powered = pwr_r;
   assign test_drive        = test_r;
endmodule
`default_nettype wire

// File: tb/adc_decoder_sva.sv
// Assertions on the decoder top ports.
// Assumes a single clock domain; bound into every decoder instance.
`default_nettype none
module adc_decoder_sva #(
   parameter int ADDR_W = 4
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       chip_select_n,
   input wire logic       conv_inhibit,
   input wire logic       power_down_pin,
   input wire logic       conv_start,
   input wire logic       conv_abort,
   input wire logic [5:0] acq_cycles,
   input wire logic       converter_powered,
   input wire logic       test_drive,
   input wire logic [8:0] device_status_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] up_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Status only settled two edges after release
   always_ff @(posedge clk) up_r <= rst_n ? {up_r[0], 1'b1} : 2'b00;
   a_reset_defaults: assert property ($rose(rst_n) |-> ##2
      device_status_word == 9'h0d0 && acq_cycles == 6'h0a && converter_powered)
      else $error("defaults wrong after reset");
   a_len_onehot: assert property (up_r[1] |-> $onehot(device_status_word[5:3]))
      else $error("length flags not one-hot");
   a_acq_legal: assert property (up_r[1] |-> acq_cycles inside {6'h06, 6'h0a, 6'h12, 6'h22})
      else $error("illegal acquisition time");
   a_start_single: assert property (conv_start |=> !conv_start)
      else $error("start pulse too long");
   a_abort_cs: assert property ($rose(conv_abort) |-> !chip_select_n)
      else $error("abort without chip select low");
   a_test_flag: assert property ($rose(test_drive) |-> ##[0:2] device_status_word[8])
      else $error("test flag missing");
   a_pin_down: assert property (power_down_pin [*6] |-> !converter_powered)
      else $error("pin did not power down");
   a_inhibit_nostart: assert property (conv_inhibit [*8] |-> !conv_start)
      else $error("start while inhibited");
   a_idle_nostart: assert property (chip_select_n [*8] |-> !conv_start)
      else $error("start while idle");
   a_cal_keeps_fmt: assert property ($rose(device_status_word[2]) |->
      $stable(device_status_word[8:3])) else $error("calibration changed format");
   a_pwr_exclusive: assert property (!(device_status_word[0] && device_status_word[1]))
      else $error("power up and down together");
   c_abort: cover property (conv_abort);
   c_cal: cover property ($rose(device_status_word[2]));
   c_test: cover property ($rose(test_drive));
endmodule
bind adc_serial_instruction_decoder adc_decoder_sva #(.ADDR_W(ADDR_W)) sva_i (
   .clk, .rst_n, .chip_select_n, .conv_inhibit, .power_down_pin, .conv_start, .conv_abort,
   .acq_cycles, .converter_powered, .test_drive, .device_status_word);
`default_nettype wire

// File: tb/host_model.sv
// Host model: shifts instruction frames in, collects the bits coming back.
// Assumes clk is the bench clock; serial clock is 20 clk per period.
`default_nettype none
module host_model (
   input  wire logic clk,
   input  wire logic dout,
   output var logic  cs_n,
   output var logic  sclk,
   output var logic  din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Serial clock stands low outside frames; spare bits toggle
   task automatic frame(input logic [7:0] ins, input int n, output logic [16:0] rx);
      rx = '0;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         din <= (i < 8) ? ins[7 - i] : ~din;
         repeat (10) @(posedge clk);
         sclk <= 1'b1;
         rx = {rx[15:0], dout};
         repeat (10) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (10) @(posedge clk);
      cs_n <= 1'b1;
      din <= ~din;
   endtask
endmodule
`default_nettype wire

// File: tb/adc_serial_instruction_decoder_test.sv
// Bench for the serial instruction decoder with a configuration model.
// Assumes host_model and the checker are compiled before it.
`default_nettype none
module adc_serial_instruction_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, conv_inhibit = 1'b0, power_down_pin = 1'b0;
   logic        conv_done = 1'b0, sg = 1'b1, msb = 1'b1, tm = 1'b0;
   logic        cs_n, sclk, din, dout, conv_start, conv_abort, conv_8bit, single_ended;
   logic        swap_polarity, converter_powered, test_drive;
   logic [1:0]  conv_kind, cdiv = 2'h0;
   logic [2:0]  channel_sel;
   logic [3:0]  fmts [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
   logic [5:0]  acq_cycles;
   logic [8:0]  device_status_word;
   logic [12:0] conv_result = 13'h0000, exp_res = 13'h0000, prv;
   logic [16:0] rx;
   int          num_errors = 0, checked = 0, seed = 52, cyc = 0, nstart = 0, nabort = 0;
   int          ecnt = 0, edly = 30, w = 12, n = 13, r, a, acqs [4] = '{6, 10, 18, 34};
   always #4 clk = ~clk;
   always @(posedge clk) cdiv <= cdiv + 2'h1;
   adc_serial_instruction_decoder adc_serial_instruction_decoder_i (
      .clk, .rst_n, .chip_select_n(cs_n), .serial_clock(sclk), .serial_instruction_in(din),
      .conv_inhibit, .power_down_pin, .conversion_clock(cdiv[1]), .conv_done, .conv_result,
      .serial_data_out(dout), .conv_start, .conv_abort, .conv_kind, .conv_8bit, .single_ended,
      .swap_polarity, .channel_sel, .acq_cycles, .converter_powered, .test_drive,
      .device_status_word);
   host_model host_model_i (.clk, .dout, .cs_n, .sclk, .din);
   // Engine stand-in: answers a start after edly cycles unless aborted
   always @(posedge clk) begin
      conv_done <= 1'b0;
      cyc <= cyc + 1;
      if (conv_start === 1'b1) begin
         ecnt <= edly;
         nstart <= nstart + 1;
      end else if (conv_abort === 1'b1) begin
         ecnt <= 0;
         nabort <= nabort + 1;
      end else if (ecnt > 0) begin
         ecnt <= ecnt - 1;
         if (ecnt == 1) begin
            r = $random(seed);
            conv_done <= 1'b1;
            conv_result <= r[12:0];
            exp_res <= r[12:0];
         end
      end
      if (cyc == 60000) begin
         num_errors++;
         final_report();
      end
   end
   function automatic logic [16:0] st_exp();
      return {8'h00, tm, msb, sg, w == 16, w == 12, w == 8, 3'b000};
   endfunction
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Frame length follows the format chosen by the previous command
   task automatic cmd(input logic [7:0] ins, input int conv);
      int s0;
      s0 = nstart;
      prv = exp_res;
      host_model_i.frame(ins, n, rx);
      repeat (50) @(posedge clk);
      chk(nstart - s0, conv);
      chk({8'h00, device_status_word[8:3], 3'b000}, st_exp());
      n = w + sg;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(device_status_word, 9'h0d0);
      chk(acq_cycles, 6'h0a);
      chk(converter_powered, 1'b1);
      cmd(8'h00, 1);
      cmd(8'h00, 1);
      chk(rx[12:0], prv);
      conv_inhibit <= 1'b1;
      cmd(8'h10, 0);
      chk(rx[12:0], prv);
      conv_inhibit <= 1'b0;
      $display("test reset and readout done");
      for (int k = 0; k < 4; k++) begin
         a = $random(seed);
         cmd({a[3:0], 4'h0}, 1);
         chk(single_ended, a[3]);
         chk(swap_polarity & !a[3], a[2] & !a[3]);
         chk(channel_sel, a[3] ? {a[1:0], a[2]} : {a[1:0], 1'b0});
      end
      for (int s = 1; s >= 0; s--) begin
         sg = s[0];
         cmd(s ? 8'h8d : 8'h0d, 0);
         foreach (fmts[i]) begin
            w = (fmts[i][1:0] == 2'b00) ? 12 : (fmts[i][1:0] == 2'b01) ? 16 : 8;
            msb = !fmts[i][2];
            cmd({4'h0, fmts[i]}, 1);
            chk(conv_8bit, w == 8);
         end
      end
      w = 12;
      msb = 1'b1;
      cmd(8'h03, 1);
      chk(conv_kind, 2'h1);
      msb = 1'b0;
      cmd(8'h07, 1);
      chk(conv_kind, 2'h2);
      $display("test formats done");
      for (int k = 0; k < 4; k++) begin
         cmd({k[1:0], 6'h0e}, 0);
         chk(acq_cycles, acqs[k]);
         if (k == 0) begin
            for (int i = 0; i < 12; i++) chk(rx[i], prv[11 - i]);
         end
      end
      cmd(8'h1b, 0);
      chk(converter_powered, 1'b1);
      cmd(8'h58, 0);
      chk(device_status_word[2], 1'b0);
      tm = 1'b1;
      cmd(8'hbf, 0);
      chk(test_drive, 1'b1);
      tm = 1'b0;
      cmd(8'h0f, 0);
      chk(test_drive, 1'b0);
      $display("test acquisition and modes done");
      cmd(8'h08, 0);
      chk(device_status_word[2], 1'b1);
      for (int k = 0; k < 1000 && device_status_word[2] !== 1'b0; k++) begin
         @(posedge clk);
      end
      chk(device_status_word[2], 1'b0);
      cmd(8'h09, 0);
      cmd(8'h0c, 0);
      cmd(8'h0b, 0);
      chk(rx[11:3], st_exp());
      chk(converter_powered, 1'b0);
      cmd(8'h0a, 0);
      chk(converter_powered, 1'b1);
      power_down_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk(converter_powered, 1'b0);
      power_down_pin <= 1'b0;
      $display("test calibration and power done");
      a = nabort;
      msb = 1'b1;
      edly = 400;
      cmd(8'h00, 1);
      edly = 30;
      cmd(8'h00, 1);
      chk(nabort - a, 1);
      $display("test abort done");
      repeat (50) @(posedge clk);
      final_report();
   end
endmodule
`default_nettype wire
